// >>> core/ctd_core.sv
// Instruction timing, branch outcome and add-flag logic of the core
`timescale 1ns/100ps
module ctd_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction issue
  input wire logic issue,
  input ctd_pkg::ctd_req_t req,
  input ctd_pkg::ctd_flags_t cur_flags,
  input wire logic mem_wait,
  // Progress
  output logic busy_q,
  output logic done_q,
  output logic [7:0] clocks_q,
  output logic fault_q,
  // Results
  output logic [15:0] result_q,
  output logic dest_we_q,
  output ctd_pkg::ctd_flags_t flags_q,
  output logic flags_we_q,
  output logic [15:0] ptr_d_q,
  output logic [15:0] ptr_s_q,
  output logic bit_out_q,
  output logic bit_we_q,
  // Control flow
  output logic jump_q,
  output logic [23:0] addr_q,
  output logic trap_q,
  output logic [3:0] trap_vec_q,
  output logic sw_reset_q
);

  // ********************************
  // Functions
  // ********************************
  function automatic logic outcome(input ctd_pkg::ctd_req_t r, input ctd_pkg::ctd_flags_t f);
    logic t;
    logic [15:0] dec;
    t = 1'b0;
    dec = r.a - ctd_pkg::STEP_BYTE;
    unique case (r.op)
      ctd_pkg::OP_BCOND: begin
        unique case (r.cond)
          ctd_pkg::CND_CC: t = !f.c;
          ctd_pkg::CND_CS: t = f.c;
          ctd_pkg::CND_EQ: t = f.z;
          ctd_pkg::CND_NE: t = !f.z;
          ctd_pkg::CND_GU: t = !f.c && !f.z;
          ctd_pkg::CND_GE: t = f.n == f.v;
          ctd_pkg::CND_GT: t = !f.z && (f.n == f.v);
          ctd_pkg::CND_LEU: t = f.c || f.z;
          ctd_pkg::CND_LE: t = f.z || (f.n != f.v);
          ctd_pkg::CND_LT: t = f.n != f.v;
          ctd_pkg::CND_MI: t = f.n;
          ctd_pkg::CND_PL: t = !f.n;
          ctd_pkg::CND_NV: t = !f.v;
          ctd_pkg::CND_OV: t = f.v;
          default: t = 1'b1;
        endcase
      end
      ctd_pkg::OP_CMP_JUMP_MEM, ctd_pkg::OP_CMP_JUMP_IMM: begin
        t = r.operand_size_bit ? (r.a != r.b) : (r.a[7:0] != r.b[7:0]);
      end
      ctd_pkg::OP_DEC_JUMP_REG, ctd_pkg::OP_DEC_JUMP_MEM: begin
        t = r.operand_size_bit ? (dec != 16'h0000) : (dec[7:0] != 8'h00);
      end
      ctd_pkg::OP_JUMP_BIT_CLR: t = r.bit_val;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Count for the selected outcome; never below one cycle
  function automatic logic [7:0] clocks_of(input ctd_pkg::ctd_req_t r, input logic t);
    logic [7:0] c;
    logic [7:0] n;
    n = {3'h0, r.count};
    unique case (r.op)
      ctd_pkg::OP_MOV_RR: c = ctd_pkg::CLK_MOV_RR;
      ctd_pkg::OP_MOV_DISP16: c = ctd_pkg::CLK_MOV_DISP16;
      ctd_pkg::OP_MOV_MEM_MEM: c = ctd_pkg::CLK_MOV_MEM_MEM;
      ctd_pkg::OP_USER_STACK: c = ctd_pkg::CLK_USER_STACK;
      ctd_pkg::OP_SHORT_IMM: c = ctd_pkg::CLK_SHORT_IMM;
      ctd_pkg::OP_CODE_READ: c = ctd_pkg::CLK_CODE_READ;
      ctd_pkg::OP_EXT_MOVE: c = ctd_pkg::CLK_EXT_MOVE;
      ctd_pkg::OP_PUSH_MULTI: c = n * ctd_pkg::CLK_PUSH_PER;
      ctd_pkg::OP_POP_MULTI: c = n * ctd_pkg::CLK_POP_PER;
      ctd_pkg::OP_BCOND: c = t ? ctd_pkg::CLK_BR_T : ctd_pkg::CLK_BR_NT;
      ctd_pkg::OP_CALL_REG: c = r.page_zero_mode ? ctd_pkg::CLK_CALL_PZ : ctd_pkg::CLK_CALL;
      ctd_pkg::OP_CMP_JUMP_MEM: c = t ? ctd_pkg::CLK_CJM_T : ctd_pkg::CLK_CJM_NT;
      ctd_pkg::OP_CMP_JUMP_IMM: c = t ? ctd_pkg::CLK_CJI_T : ctd_pkg::CLK_CJI_NT;
      ctd_pkg::OP_DEC_JUMP_REG: c = t ? ctd_pkg::CLK_DJR_T : ctd_pkg::CLK_DJR_NT;
      ctd_pkg::OP_DEC_JUMP_MEM: c = t ? ctd_pkg::CLK_DJM_T : ctd_pkg::CLK_DJM_NT;
      ctd_pkg::OP_FAR_JUMP: c = ctd_pkg::CLK_FAR;
      ctd_pkg::OP_JUMP_BIT_CLR: c = t ? ctd_pkg::CLK_JBC_T : ctd_pkg::CLK_JBC_NT;
      ctd_pkg::OP_JUMP_DIND: c = ctd_pkg::CLK_DIND;
      ctd_pkg::OP_BIT: c = ctd_pkg::CLK_BIT;
      ctd_pkg::OP_BREAK, ctd_pkg::OP_TRAP: begin
        c = r.page_zero_mode ? ctd_pkg::CLK_TRAP_PZ : ctd_pkg::CLK_TRAP;
      end
      ctd_pkg::OP_SW_RESET: c = ctd_pkg::CLK_RESET;
      ctd_pkg::OP_SHIFT: begin
        c = (r.shift32 ? ctd_pkg::CLK_SHIFT32 : ctd_pkg::CLK_SHIFT) + {4'h0, r.count[4:1]};
      end
      ctd_pkg::OP_ADD: c = ctd_pkg::CLK_ADD;
      default: c = ctd_pkg::CLK_MIN;
    endcase
    if (c < ctd_pkg::CLK_MIN) begin
      c = ctd_pkg::CLK_MIN;
    end
    return c;
  endfunction

  // ********************************
  // Sequencer state
  // ********************************
  typedef enum logic {ST_IDLE, ST_EXEC} ctd_state_t;

  ctd_state_t state_q, state_d;
  ctd_pkg::ctd_req_t req_q, req_d;
  logic taken_q, taken_d;
  logic [7:0] rem_q, rem_d;
  logic busy_d, done_d, fault_d, dest_we_d, flags_we_d, bit_out_d, bit_we_d;
  logic jump_d, trap_d, sw_reset_d;
  logic [7:0] clocks_d;
  logic [15:0] result_d, ptr_d_d, ptr_s_d;
  logic [23:0] addr_d;
  logic [3:0] trap_vec_d;
  ctd_pkg::ctd_flags_t flags_d;

  logic t_now;
  logic [15:0] step;
  logic [16:0] sum;
  logic [4:0] nib;
  logic bit_in;

  assign t_now = outcome(req, cur_flags);
  assign step = req_q.operand_size_bit ? ctd_pkg::STEP_WORD : ctd_pkg::STEP_BYTE;
  assign sum = req_q.operand_size_bit ? ({1'b0, req_q.a} + {1'b0, req_q.b})
                                      : {8'h00, {1'b0, req_q.a[7:0]} + {1'b0, req_q.b[7:0]}};
  assign nib = {1'b0, req_q.a[3:0]} + {1'b0, req_q.b[3:0]};
  assign bit_in = req_q.bit_val;

  // ********************************
  // Next-state logic
  // ********************************
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    taken_d = taken_q;
    rem_d = rem_q;
    busy_d = busy_q;
    clocks_d = clocks_q;
    done_d = 1'b0;
    fault_d = 1'b0;
    dest_we_d = 1'b0;
    flags_we_d = 1'b0;
    bit_we_d = 1'b0;
    jump_d = 1'b0;
    trap_d = 1'b0;
    sw_reset_d = 1'b0;
    bit_out_d = bit_out_q;
    result_d = result_q;
    flags_d = flags_q;
    ptr_d_d = ptr_d_q;
    ptr_s_d = ptr_s_q;
    addr_d = addr_q;
    trap_vec_d = trap_vec_q;
    unique case (state_q)
      ST_IDLE: begin
        if (issue) begin
          state_d = ST_EXEC;
          req_d = req;
          taken_d = t_now;
          clocks_d = clocks_of(req, t_now);
          rem_d = clocks_of(req, t_now) - ctd_pkg::CLK_MIN;
          busy_d = 1'b1;
        end
      end
      ST_EXEC: begin
        // A wait cycle holds the countdown, so it adds one clock each
        if (!mem_wait) begin
          rem_d = rem_q - ctd_pkg::CLK_MIN;
        end
        if (!mem_wait && rem_q == 8'h00) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
          jump_d = taken_q;
          ptr_d_d = req_q.ptr_d;
          ptr_s_d = req_q.ptr_s;
          addr_d = req_q.addr24;
          unique case (req_q.op)
            ctd_pkg::OP_MOV_RR, ctd_pkg::OP_MOV_DISP16, ctd_pkg::OP_EXT_MOVE: begin
              result_d = req_q.a;
              dest_we_d = 1'b1;
            end
            ctd_pkg::OP_MOV_MEM_MEM: begin
              result_d = req_q.mem_word;
              dest_we_d = 1'b1;
              ptr_d_d = req_q.ptr_d + step;
              ptr_s_d = req_q.ptr_s + step;
            end
            ctd_pkg::OP_USER_STACK: begin
              // Outside system mode the access is dropped and flagged
              result_d = req_q.a;
              dest_we_d = req_q.system_mode;
              fault_d = !req_q.system_mode;
            end
            ctd_pkg::OP_SHORT_IMM: begin
              result_d = req_q.operand_size_bit ? {{12{req_q.imm4[3]}}, req_q.imm4}
                                                : {8'h00, {4{req_q.imm4[3]}}, req_q.imm4};
              dest_we_d = 1'b1;
            end
            ctd_pkg::OP_CODE_READ: begin
              addr_d = {req_q.addr24[23:16], req_q.a + req_q.b};
              result_d = req_q.mem_word;
              dest_we_d = 1'b1;
            end
            ctd_pkg::OP_PUSH_MULTI, ctd_pkg::OP_POP_MULTI, ctd_pkg::OP_SHIFT: begin
              result_d = req_q.a;
            end
            ctd_pkg::OP_BCOND, ctd_pkg::OP_CMP_JUMP_MEM, ctd_pkg::OP_CMP_JUMP_IMM: begin
              result_d = req_q.a;
            end
            ctd_pkg::OP_DEC_JUMP_REG, ctd_pkg::OP_DEC_JUMP_MEM: begin
              result_d = req_q.a - ctd_pkg::STEP_BYTE;
              dest_we_d = 1'b1;
            end
            ctd_pkg::OP_CALL_REG: begin
              addr_d = {req_q.addr24[23:16], req_q.a};
              jump_d = 1'b1;
            end
            ctd_pkg::OP_FAR_JUMP: jump_d = 1'b1;
            ctd_pkg::OP_JUMP_BIT_CLR: begin
              bit_out_d = 1'b0;
              bit_we_d = taken_q;
            end
            ctd_pkg::OP_JUMP_DIND: begin
              addr_d = {req_q.addr24[23:16], req_q.mem_word};
              ptr_s_d = req_q.ptr_s + ctd_pkg::STEP_WORD;
              jump_d = 1'b1;
            end
            ctd_pkg::OP_BIT: begin
              flags_d = cur_flags;
              unique case (req_q.bitop)
                ctd_pkg::BIT_AND: flags_d.c = cur_flags.c & bit_in;
                ctd_pkg::BIT_AND_N: flags_d.c = cur_flags.c & !bit_in;
                ctd_pkg::BIT_OR: flags_d.c = cur_flags.c | bit_in;
                ctd_pkg::BIT_OR_N: flags_d.c = cur_flags.c | !bit_in;
                ctd_pkg::BIT_TO_C: flags_d.c = bit_in;
                ctd_pkg::BIT_CLR: bit_out_d = 1'b0;
                ctd_pkg::BIT_SET: bit_out_d = 1'b1;
                ctd_pkg::BIT_FROM_C: bit_out_d = cur_flags.c;
              endcase
              flags_we_d = req_q.bitop inside {ctd_pkg::BIT_AND, ctd_pkg::BIT_AND_N, ctd_pkg::BIT_OR,
                                              ctd_pkg::BIT_OR_N, ctd_pkg::BIT_TO_C};
              bit_we_d = !flags_we_d;
            end
            ctd_pkg::OP_BREAK: begin
              trap_d = 1'b1;
              trap_vec_d = ctd_pkg::BREAK_VEC;
            end
            ctd_pkg::OP_TRAP: begin
              trap_d = 1'b1;
              trap_vec_d = req_q.imm4;
            end
            // Goes to the chip reset generator, same path as the pin
            ctd_pkg::OP_SW_RESET: sw_reset_d = 1'b1;
            ctd_pkg::OP_ADD: begin
              result_d = sum[15:0];
              dest_we_d = 1'b1;
              flags_we_d = 1'b1;
              flags_d.ac = nib[4];
              if (req_q.operand_size_bit) begin
                flags_d.c = sum[16];
                flags_d.n = sum[15];
                flags_d.z = sum[15:0] == 16'h0000;
                flags_d.v = (req_q.a[15] == req_q.b[15]) && (sum[15] != req_q.a[15]);
              end else begin
                flags_d.c = sum[8];
                flags_d.n = sum[7];
                flags_d.z = sum[7:0] == 8'h00;
                flags_d.v = (req_q.a[7] == req_q.b[7]) && (sum[7] != req_q.a[7]);
              end
              if (req_q.to_status_low) begin
                // The written byte wins over the computed flags
                flags_d.c = sum[ctd_pkg::PSW_C];
                flags_d.ac = sum[ctd_pkg::PSW_AC];
                flags_d.v = sum[ctd_pkg::PSW_V];
                flags_d.n = sum[ctd_pkg::PSW_N];
                flags_d.z = sum[ctd_pkg::PSW_Z];
              end
            end
            default: fault_d = 1'b1;
          endcase
        end
      end
    endcase
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      taken_q <= 1'b0;
      rem_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      clocks_q <= 8'h00;
      fault_q <= 1'b0;
      result_q <= 16'h0000;
      dest_we_q <= 1'b0;
      flags_q <= '0;
      flags_we_q <= 1'b0;
      ptr_d_q <= 16'h0000;
      ptr_s_q <= 16'h0000;
      bit_out_q <= 1'b0;
      bit_we_q <= 1'b0;
      jump_q <= 1'b0;
      addr_q <= 24'h000000;
      trap_q <= 1'b0;
      trap_vec_q <= 4'h0;
      sw_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      taken_q <= taken_d;
      rem_q <= rem_d;
      busy_q <= busy_d;
      done_q <= done_d;
      clocks_q <= clocks_d;
      fault_q <= fault_d;
      result_q <= result_d;
      dest_we_q <= dest_we_d;
      flags_q <= flags_d;
      flags_we_q <= flags_we_d;
      ptr_d_q <= ptr_d_d;
      ptr_s_q <= ptr_s_d;
      bit_out_q <= bit_out_d;
      bit_we_q <= bit_we_d;
      jump_q <= jump_d;
      addr_q <= addr_d;
      trap_q <= trap_d;
      trap_vec_q <= trap_vec_d;
      sw_reset_q <= sw_reset_d;
    end
  end

  // ********************************
  // Checks
  // ********************************
  logic [7:0] lat_q, wait_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= 8'h00;
      wait_q <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      lat_q <= 8'h00;
      wait_q <= 8'h00;
    end else begin
      lat_q <= lat_q + 8'h01;
      wait_q <= wait_q + {7'h00, mem_wait};
    end
  end

  a_done_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q |-> lat_q == clocks_q + wait_q) else $error("completion not at count plus waits");
  a_copy_clocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_MOV_RR |-> lat_q - wait_q == 8'h03) else $error("copy not 3 clocks");
  a_disp_clocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_MOV_DISP16 |-> lat_q - wait_q == 8'h05) else $error("disp copy not 5");
  a_branch_clocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_BCOND |-> lat_q - wait_q == (jump_q ? 8'h06 : 8'h03))
    else $error("branch clocks wrong");
  a_sext_imm: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_SHORT_IMM |-> result_q[3:0] == req_q.imm4
    && result_q[7:4] == {4{req_q.imm4[3]}}) else $error("short immediate not sign-extended");
  a_stack_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_USER_STACK |-> fault_q == !req_q.system_mode && dest_we_q != fault_q)
    else $error("user stack access guard wrong");
  a_trap_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_TRAP |-> trap_q && trap_vec_q == req_q.imm4) else $error("trap vector wrong");
  a_jbc_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_JUMP_BIT_CLR |-> jump_q == req_q.bit_val && bit_we_q == jump_q && !bit_out_q)
    else $error("jump on bit did not clear");
  a_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sw_reset_q |-> done_q && lat_q - wait_q == 8'h08 ##1 !sw_reset_q) else $error("software reset timing wrong");
  a_psw_override: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && req_q.op == ctd_pkg::OP_ADD && req_q.to_status_low |-> flags_q.c == result_q[ctd_pkg::PSW_C]
    && flags_q.z == result_q[ctd_pkg::PSW_Z]) else $error("status write did not win");

endmodule

// >>> shared/ctd_pkg.sv
// Constants, opcodes and carriers for the instruction timing decoder
package ctd_pkg;

  // ********************************
  // Instruction classes
  // ********************************
  typedef enum logic [4:0] {
    OP_MOV_RR, OP_MOV_DISP16, OP_MOV_MEM_MEM, OP_USER_STACK, OP_SHORT_IMM,
    OP_CODE_READ, OP_EXT_MOVE, OP_PUSH_MULTI, OP_POP_MULTI, OP_BCOND,
    OP_CALL_REG, OP_CMP_JUMP_MEM, OP_CMP_JUMP_IMM, OP_DEC_JUMP_REG, OP_DEC_JUMP_MEM,
    OP_FAR_JUMP, OP_JUMP_BIT_CLR, OP_JUMP_DIND, OP_BIT, OP_BREAK, OP_SW_RESET,
    OP_TRAP, OP_SHIFT, OP_ADD
  } ctd_op_t;

  typedef enum logic [3:0] {
    CND_CC, CND_CS, CND_EQ, CND_NE, CND_GU, CND_GE, CND_GT, CND_LEU,
    CND_LE, CND_LT, CND_MI, CND_PL, CND_NV, CND_OV, CND_AL
  } ctd_cond_t;

  typedef enum logic [2:0] {
    BIT_AND, BIT_AND_N, BIT_OR, BIT_OR_N, BIT_CLR, BIT_SET, BIT_TO_C, BIT_FROM_C
  } ctd_bitop_t;

  // ********************************
  // Carriers
  // ********************************
  typedef struct packed {
    logic c;
    logic ac;
    logic v;
    logic n;
    logic z;
  } ctd_flags_t;

  typedef struct packed {
    ctd_op_t op;
    logic operand_size_bit;
    logic page_zero_mode;
    logic system_mode;
    logic to_status_low;
    logic shift32;
    ctd_cond_t cond;
    ctd_bitop_t bitop;
    logic [3:0] imm4;
    logic [4:0] count;
    logic bit_val;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] mem_word;
    logic [15:0] ptr_d;
    logic [15:0] ptr_s;
    logic [23:0] addr24;
  } ctd_req_t;

  // ********************************
  // Zero-wait clock counts
  // ********************************
  localparam logic [7:0] CLK_MOV_RR = 8'h03;
  localparam logic [7:0] CLK_MOV_DISP16 = 8'h05;
  localparam logic [7:0] CLK_MOV_MEM_MEM = 8'h06;
  localparam logic [7:0] CLK_USER_STACK = 8'h03;
  localparam logic [7:0] CLK_SHORT_IMM = 8'h03;
  localparam logic [7:0] CLK_CODE_READ = 8'h06;
  localparam logic [7:0] CLK_EXT_MOVE = 8'h06;
  localparam logic [7:0] CLK_PUSH_PER = 8'h03;
  localparam logic [7:0] CLK_POP_PER = 8'h02;
  localparam logic [7:0] CLK_BR_T = 8'h06;
  localparam logic [7:0] CLK_BR_NT = 8'h03;
  localparam logic [7:0] CLK_CALL = 8'h08;
  localparam logic [7:0] CLK_CALL_PZ = 8'h05;
  localparam logic [7:0] CLK_CJM_T = 8'h0a;
  localparam logic [7:0] CLK_CJM_NT = 8'h07;
  localparam logic [7:0] CLK_CJI_T = 8'h09;
  localparam logic [7:0] CLK_CJI_NT = 8'h06;
  localparam logic [7:0] CLK_DJR_T = 8'h08;
  localparam logic [7:0] CLK_DJR_NT = 8'h05;
  localparam logic [7:0] CLK_DJM_T = 8'h09;
  localparam logic [7:0] CLK_DJM_NT = 8'h06;
  localparam logic [7:0] CLK_FAR = 8'h06;
  localparam logic [7:0] CLK_JBC_T = 8'h07;
  localparam logic [7:0] CLK_JBC_NT = 8'h04;
  localparam logic [7:0] CLK_DIND = 8'h08;
  localparam logic [7:0] CLK_BIT = 8'h04;
  localparam logic [7:0] CLK_TRAP = 8'h17;
  localparam logic [7:0] CLK_TRAP_PZ = 8'h13;
  localparam logic [7:0] CLK_RESET = 8'h08;
  localparam logic [7:0] CLK_SHIFT = 8'h04;
  localparam logic [7:0] CLK_SHIFT32 = 8'h06;
  localparam logic [7:0] CLK_ADD = 8'h03;
  localparam logic [7:0] CLK_MIN = 8'h01;

  // ********************************
  // Status low byte layout and vectors
  // ********************************
  localparam int PSW_C = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_V = 2;
  localparam int PSW_N = 1;
  localparam int PSW_Z = 0;
  localparam logic [3:0] BREAK_VEC = 4'h0;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

endpackage

// >>> testbench/ctd_mem_model.sv
// Memory wait-state model standing at the far side of the core
`timescale 1ns/100ps
module ctd_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core handshake
  input wire logic issue,
  input wire logic busy_q,
  input wire logic [1:0] nwait,
  // Wait output
  output logic mem_wait
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (issue && !busy_q) begin
      cnt_d = nwait;
    end else if (cnt_q != 2'h0) begin
      cnt_d = cnt_q - 2'h1;
    end
  end
  // Stalls start only after a take, so every wait cycle lies inside execution
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_d;
  end
  assign mem_wait = (cnt_q != 2'h0);
endmodule

// >>> testbench/test_cpu_instruction_timing_decode.sv
// Self-checking bench for the instruction timing decoder
`timescale 1ns/100ps
module test_cpu_instruction_timing_decode;
  // ****
  // Signals and instances
  // ****
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  ctd_pkg::ctd_req_t req = '0;
  ctd_pkg::ctd_flags_t cur_flags = '0;
  logic [1:0] nwait = 2'h0;
  logic mem_wait, busy_q, done_q, fault_q, dest_we_q, flags_we_q, bit_out_q, bit_we_q, jump_q, trap_q, sw_reset_q;
  logic [7:0] clocks_q;
  logic [15:0] result_q, ptr_d_q, ptr_s_q;
  ctd_pkg::ctd_flags_t flags_q;
  logic [23:0] addr_q;
  logic [3:0] trap_vec_q;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int nt_clk [24] = '{3, 5, 6, 3, 3, 6, 6, 0, 0, 3, 8, 7, 6, 5, 6, 6, 4, 8, 4, 23, 8, 23, 4, 3};
  ctd_pkg::ctd_req_t r;
  ctd_core u_dut (.ref_clk, .rst_n, .issue, .req, .cur_flags, .mem_wait, .busy_q, .done_q, .clocks_q, .fault_q,
    .result_q, .dest_we_q, .flags_q, .flags_we_q, .ptr_d_q, .ptr_s_q, .bit_out_q, .bit_we_q, .jump_q, .addr_q,
    .trap_q, .trap_vec_q, .sw_reset_q);
  ctd_mem_model u_mem (.ref_clk, .rst_n, .issue, .busy_q, .nwait, .mem_wait);
  initial forever #2 ref_clk = ~ref_clk;
  // ****
  // Checking and reference model
  // ****
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  function automatic logic cond_hit(input logic [3:0] c, input ctd_pkg::ctd_flags_t f);
    case (c)
      4'h0: return !f.c;
      4'h1: return f.c;
      4'h2: return f.z;
      4'h3: return !f.z;
      4'h4: return !f.c && !f.z;
      4'h5: return f.n == f.v;
      4'h6: return !f.z && (f.n == f.v);
      4'h7: return f.c || f.z;
      4'h8: return f.z || (f.n != f.v);
      4'h9: return f.n != f.v;
      4'ha: return f.n;
      4'hb: return !f.n;
      4'hc: return !f.v;
      4'hd: return f.v;
      default: return 1'b1;
    endcase
  endfunction
  // Issues one instruction right away, so back-to-back issue happens in the done cycle
  task automatic run(input ctd_pkg::ctd_req_t q, input ctd_pkg::ctd_flags_t f, input logic [1:0] w);
    int n, e, o, hb;
    logic tk, eb, bw;
    logic [15:0] m, sx;
    logic [16:0] sm;
    logic [4:0] lo;
    ctd_pkg::ctd_flags_t ef;
    n = 0;
    o = int'(q.op);
    m = q.operand_size_bit ? 16'hffff : 16'h00ff;
    hb = q.operand_size_bit ? 15 : 7;
    e = (o < 24) ? nt_clk[o] : 1;
    tk = 1'b0;
    case (o)
      7: e = (q.count == 0) ? 1 : 3 * q.count;
      8: e = (q.count == 0) ? 1 : 2 * q.count;
      9: tk = cond_hit(q.cond, f);
      10: e = q.page_zero_mode ? 5 : 8;
      11, 12: tk = ((q.a & m) != (q.b & m));
      13, 14: tk = (((q.a - 16'h0001) & m) != 16'h0000);
      16: tk = q.bit_val;
      19, 21: e = q.page_zero_mode ? 19 : 23;
      22: e = (q.shift32 ? 6 : 4) + (q.count >> 1);
      default: ;
    endcase
    if (tk) e += 3;
    issue = 1'b1;
    req = q;
    cur_flags = f;
    nwait = w;
    @(posedge ref_clk);
    #1;
    issue = 1'b0;
    chk(busy_q === 1'b1 && clocks_q === 8'(e), "busy after take");
    while (done_q !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n == e + w, "completion time");
    chk(clocks_q === 8'(e), "clock count");
    chk(busy_q === 1'b0 && fault_q === (o > 23 || (o == 3 && !q.system_mode)), "done state");
    sx = {{12{q.imm4[3]}}, q.imm4};
    sm = 17'(q.a & m) + 17'(q.b & m);
    lo = 5'(q.a[3:0]) + 5'(q.b[3:0]);
    // Bit ops either write the carry or write the addressed bit
    bw = q.bitop inside {ctd_pkg::BIT_CLR, ctd_pkg::BIT_SET, ctd_pkg::BIT_FROM_C};
    case (q.bitop)
      ctd_pkg::BIT_AND: eb = f.c & q.bit_val;
      ctd_pkg::BIT_AND_N: eb = f.c & !q.bit_val;
      ctd_pkg::BIT_OR: eb = f.c | q.bit_val;
      ctd_pkg::BIT_OR_N: eb = f.c | !q.bit_val;
      ctd_pkg::BIT_CLR: eb = 1'b0;
      ctd_pkg::BIT_SET: eb = 1'b1;
      default: eb = (q.bitop == ctd_pkg::BIT_TO_C) ? q.bit_val : f.c;
    endcase
    ef = '{sm[hb + 1], lo[4], (q.a[hb] == q.b[hb]) && (sm[hb] != q.a[hb]), sm[hb], (sm[15:0] & m) == 16'h0000};
    if (q.to_status_low) ef = '{sm[7], sm[6], sm[2], sm[1], sm[0]};
    case (o)
      2: chk(ptr_d_q === q.ptr_d + (m == 16'hffff ? 16'h2 : 16'h1) && ptr_s_q === q.ptr_s + 16'(1 + q.operand_size_bit), "post increment");
      3: chk(fault_q === !q.system_mode && dest_we_q === q.system_mode, "user stack mode");
      0, 1, 6: chk(dest_we_q === 1'b1 && result_q === q.a, "copy data");
      5: chk(result_q === q.mem_word && addr_q === {q.addr24[23:16], q.a + q.b}, "table read");
      10: chk(jump_q === 1'b1 && addr_q === {q.addr24[23:16], q.a}, "call target");
      18: chk(bw ? (bit_we_q === 1'b1 && bit_out_q === eb) : (flags_we_q === 1'b1 && flags_q.c === eb), "bit op");
      4: chk(dest_we_q === 1'b1 && result_q === (sx & m), "sign extension");
      9, 11, 12, 13, 14, 16: chk(jump_q === tk, "branch outcome");
      15: chk(jump_q === 1'b1 && addr_q === q.addr24, "far target");
      17: chk(addr_q === {q.addr24[23:16], q.mem_word} && ptr_s_q === q.ptr_s + 16'h2, "double indirect");
      19, 21: chk(trap_q === 1'b1 && trap_vec_q === (o == 21 ? q.imm4 : ctd_pkg::BREAK_VEC), "trap vector");
      20: chk(sw_reset_q === 1'b1, "reset pulse");
      23: chk((result_q & m) === (sm[15:0] & m) && flags_we_q === 1'b1 && flags_q === ef, "add");
      default: ;
    endcase
    if (o == 16 && tk) chk(bit_we_q === 1'b1 && bit_out_q === 1'b0, "bit clear");
    if (o == 13 || o == 14) chk(dest_we_q === 1'b1 && (result_q & m) === ((q.a - 16'h0001) & m), "decrement");
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(49268));
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk(busy_q === 1'b0 && done_q === 1'b0, "idle after reset");
    for (int i = 0; i < 400; i++) begin
      r = 131'({$urandom, $urandom, $urandom, $urandom, $urandom});
      r.op = ctd_pkg::ctd_op_t'(5'($urandom_range(31)));
      r.cond = ctd_pkg::ctd_cond_t'(4'($urandom_range(14)));
      if (i < 15) begin
        r.op = ctd_pkg::OP_BCOND;
        r.cond = ctd_pkg::ctd_cond_t'(4'(i));
      end
      if ($urandom_range(3) == 0) r.a = 16'h0001;
      if ($urandom_range(3) == 0) r.b = r.a;
      run(r, 5'($urandom), 2'($urandom));
    end
    // Reset in mid-instruction must abandon it at once
    r.op = ctd_pkg::OP_PUSH_MULTI;
    r.count = 5'h14;
    issue = 1'b1;
    req = r;
    repeat (5) @(posedge ref_clk);
    #1;
    issue = 1'b0;
    rst_n = 1'b0;
    #1;
    chk(busy_q === 1'b0 && done_q === 1'b0, "mid-run reset");
    @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    r.op = ctd_pkg::OP_MOV_RR;
    run(r, 5'h00, 2'h1);
    give_verdict();
  end
endmodule
